/* File: design/core_mode_pkg.sv */
// Package with field positions, reset values and timing counts.
package core_mode_pkg;
	// ------------------------------------------------------------
	// Operating mode control fields
	// ------------------------------------------------------------
	localparam int OMC_CDP_LO = 8;
	localparam int OMC_MS = 7;
	localparam int OMC_SD = 6;
	localparam int OMC_EBD = 4;
	localparam logic [23:0] OMC_WR_MASK = 24'h0003DF;
	localparam logic [1:0] CDP_RESET = 2'h3;
	localparam logic [1:0] CDP_DYNAMIC = 2'h0;
	localparam logic [1:0] CDP_DMA_HIGH = 2'h1;
	localparam logic [1:0] CDP_EQUAL = 2'h2;
	localparam logic [1:0] CDP_CORE_HIGH = 2'h3;
	// ------------------------------------------------------------
	// Status word fields
	// ------------------------------------------------------------
	localparam int PSW_CP_LO = 22;
	localparam int PSW_RM = 21;
	localparam int PSW_SM = 20;
	localparam int PSW_CE = 19;
	localparam int PSW_SA = 17;
	localparam int PSW_FV = 16;
	localparam int PSW_LF = 15;
	localparam int PSW_DM = 14;
	localparam int PSW_S = 7;
	localparam int PSW_L = 6;
	localparam logic [23:0] PSW_WR_MASK = 24'hFBEFFF;
	localparam logic [23:0] PSW_RESET = 24'hC00300;
	localparam logic [7:0] CCR_MOVE_MASK = 8'hC0;
	// ------------------------------------------------------------
	// Stop exit delays in clock cycles
	// ------------------------------------------------------------
	localparam int STOP_LONG_CYCLES = 128 * 1024;
	localparam int STOP_SHORT_CYCLES = 16;
endpackage

/* File: design/core_mode_status_registers.sv */
// Operating mode and status register bank of the processor core.
`timescale 1ns/1ps
module core_mode_status_registers
	import core_mode_pkg::*;
#(
	parameter int STOP_LONG = STOP_LONG_CYCLES,
	parameter int STOP_SHORT = STOP_SHORT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] mode_select_pins,
	input wire logic omc_write,
	input wire logic [23:0] omc_wdata,
	input wire logic psw_write,
	input wire logic [23:0] psw_wdata,
	input wire logic ccr_alu_write,
	input wire logic [7:0] ccr_alu_data,
	input wire logic ccr_move_write,
	input wire logic [7:0] ccr_move_data,
	input wire logic mr_write,
	input wire logic [7:0] mr_wdata,
	input wire logic emr_event,
	input wire logic [7:0] emr_event_data,
	input wire logic forever_loop_start,
	input wire logic loop_start,
	input wire logic loop_restore,
	input wire logic [1:0] loop_restore_flags,
	input wire logic subroutine_jump,
	input wire logic stop_exit,
	input wire logic [1:0] dma_channel_priority,
	input wire logic dma_request,
	input wire logic core_request,
	output logic [23:0] operating_mode_control,
	output logic [23:0] processor_status_word,
	output logic stack_push,
	output logic [23:0] stack_push_data,
	output logic stop_wait,
	output logic external_bus_enable,
	output logic dma_grant,
	output logic core_grant,
	output logic memory_switch_mode,
	output logic rounding_mode,
	output logic saturation_mode,
	output logic cache_enable,
	output logic sixteen_bit_arith,
	output logic double_precision_mode
);
	// Refuse stop delay counts that the down counter cannot serve
	if (STOP_LONG < 1 || STOP_SHORT < 1 || STOP_SHORT > STOP_LONG) begin
		$error("stop delay counts out of range");
	end

	// ------------------------------------------------------------
	// Pin synchroniser for mode select inputs
	// ------------------------------------------------------------
	logic [3:0] pin_s1, pin_s2, pin_s3, pin_stable;
	logic [3:0] next_pin_stable;
	logic in_reset;

	// Accept a pin change once the second and third stages agree
	always_comb begin
		next_pin_stable = pin_stable;
		if (pin_s2 == pin_s3)
			next_pin_stable = pin_s3;
	end

	always_ff @(posedge sys_clk) begin
		pin_s1 <= mode_select_pins;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
		pin_stable <= next_pin_stable;
		in_reset <= rst;
	end

	// ------------------------------------------------------------
	// Register bank
	// ------------------------------------------------------------
	logic [23:0] next_omc, next_psw;
	logic [7:0] condition_code_byte;

	// Writes, hardware events and the reset load of the mode select pins into the mode register
	always_comb begin
		next_omc = operating_mode_control;
		next_psw = processor_status_word;
		condition_code_byte = processor_status_word[7:0];
		if (omc_write)
			next_omc = omc_wdata & OMC_WR_MASK;
		if (in_reset)
			next_omc[3:0] = pin_stable;
		if (ccr_move_write)
			condition_code_byte = (condition_code_byte & ~CCR_MOVE_MASK) | (ccr_move_data & CCR_MOVE_MASK);
		if (ccr_alu_write)
			condition_code_byte = ccr_alu_data;
		next_psw[7:0] = condition_code_byte;
		if (mr_write)
			next_psw[15:8] = mr_wdata;
		if (emr_event)
			next_psw[23:16] = emr_event_data;
		if (loop_start)
			next_psw[PSW_LF] = 1'b1;
		if (forever_loop_start) begin
			next_psw[PSW_FV] = 1'b1;
			next_psw[PSW_LF] = 1'b1;
		end
		if (loop_restore) begin
			next_psw[PSW_FV] = loop_restore_flags[1];
			next_psw[PSW_LF] = loop_restore_flags[0];
		end
		if (psw_write)
			next_psw = psw_wdata;
		next_psw = next_psw & PSW_WR_MASK;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			operating_mode_control <= {14'h0, CDP_RESET, 8'h00};
			processor_status_word <= PSW_RESET;
		end else begin
			operating_mode_control <= next_omc;
			processor_status_word <= next_psw;
		end
	end

	// ------------------------------------------------------------
	// Stack push of the status word
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stack_push <= 1'b0;
			stack_push_data <= 24'h000000;
		end else begin
			stack_push <= loop_start | forever_loop_start | subroutine_jump;
			stack_push_data <= processor_status_word;
		end
	end

	// ------------------------------------------------------------
	// Stop exit delay counter
	// ------------------------------------------------------------
	logic [31:0] stop_count, next_stop_count;
	logic next_stop_wait;

	// Load the delay chosen by the stop delay bit, then count down
	always_comb begin
		next_stop_count = stop_count;
		next_stop_wait = stop_wait;
		if (stop_exit) begin
			next_stop_wait = 1'b1;
			if (operating_mode_control[OMC_SD])
				next_stop_count = 32'(STOP_SHORT - 1);
			else
				next_stop_count = 32'(STOP_LONG - 1);
		end else if (stop_wait) begin
			if (stop_count == 32'h0)
				next_stop_wait = 1'b0;
			else
				next_stop_count = stop_count - 32'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stop_count <= 32'h0;
			stop_wait <= 1'b0;
		end else begin
			stop_count <= next_stop_count;
			stop_wait <= next_stop_wait;
		end
	end

	// ------------------------------------------------------------
	// External bus arbitration between core and DMA
	// ------------------------------------------------------------
	logic [1:0] rr_slot, next_rr_slot;
	logic next_dma_grant, next_core_grant, dma_first;
	logic [1:0] sel, cp;

	// Pick the winner from selector mode and priorities
	always_comb begin
		sel = operating_mode_control[OMC_CDP_LO +: 2];
		cp = processor_status_word[PSW_CP_LO +: 2];
		next_rr_slot = rr_slot;
		dma_first = 1'b0;
		unique case (sel)
			CDP_DYNAMIC: begin
				if (dma_channel_priority > cp)
					dma_first = 1'b1;
				else if (dma_channel_priority == cp)
					dma_first = (rr_slot == 2'h3);
			end
			CDP_DMA_HIGH: dma_first = 1'b1;
			CDP_EQUAL: dma_first = (rr_slot == 2'h3);
			CDP_CORE_HIGH: dma_first = 1'b0;
		endcase
		next_dma_grant = 1'b0;
		next_core_grant = 1'b0;
		if (!operating_mode_control[OMC_EBD]) begin
			if (dma_request && (dma_first || !core_request))
				next_dma_grant = 1'b1;
			else if (core_request)
				next_core_grant = 1'b1;
			// Round robin P, X, Y, DMA advances on each grant
			if (dma_request || core_request)
				next_rr_slot = rr_slot + 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rr_slot <= 2'h0;
			dma_grant <= 1'b0;
			core_grant <= 1'b0;
		end else begin
			rr_slot <= next_rr_slot;
			dma_grant <= next_dma_grant;
			core_grant <= next_core_grant;
		end
	end

	// ------------------------------------------------------------
	// Registered mode outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			external_bus_enable <= 1'b0;
			memory_switch_mode <= 1'b0;
			rounding_mode <= 1'b0;
			saturation_mode <= 1'b0;
			cache_enable <= 1'b0;
			sixteen_bit_arith <= 1'b0;
			double_precision_mode <= 1'b0;
		end else begin
			external_bus_enable <= !next_omc[OMC_EBD];
			memory_switch_mode <= next_omc[OMC_MS];
			rounding_mode <= next_psw[PSW_RM];
			saturation_mode <= next_psw[PSW_SM];
			cache_enable <= next_psw[PSW_CE];
			sixteen_bit_arith <= next_psw[PSW_SA];
			double_precision_mode <= next_psw[PSW_DM];
		end
	end
endmodule

/* File: verification/core_mode_props.sv */
// Checker of the mode and status register bank.
`timescale 1ns/1ps
module core_mode_props
	import core_mode_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psw_write,
	input wire logic [23:0] psw_wdata,
	input wire logic forever_loop_start,
	input wire logic loop_start,
	input wire logic subroutine_jump,
	input wire logic stop_exit,
	input wire logic dma_request,
	input wire logic core_request,
	input wire logic [23:0] operating_mode_control,
	input wire logic [23:0] processor_status_word,
	input wire logic stack_push,
	input wire logic [23:0] stack_push_data,
	input wire logic stop_wait,
	input wire logic external_bus_enable,
	input wire logic dma_grant,
	input wire logic core_grant,
	input wire logic memory_switch_mode,
	input wire logic rounding_mode
);
	logic both;
	logic [1:0] sel;
	// ----------------------------------------
	// Helpers and assertions
	// ----------------------------------------
	assign both = dma_request && core_request
		&& !operating_mode_control[OMC_EBD];
	assign sel = operating_mode_control[9:8];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_reset_values: assert property (disable iff (1'b0) rst |=>
		processor_status_word == PSW_RESET) else $error("bad reset");
	a_psw_write_mask: assert property (psw_write |=>
		processor_status_word == ($past(psw_wdata) & PSW_WR_MASK))
		else $error("bad psw write");
	a_reserved_zero: assert property (
		(operating_mode_control & ~OMC_WR_MASK) == 24'h0
		&& (processor_status_word & ~PSW_WR_MASK) == 24'h0)
		else $error("reserved bit set");
	a_push_on_loop: assert property (
		(loop_start || subroutine_jump || forever_loop_start) |=>
		stack_push && stack_push_data == $past(processor_status_word))
		else $error("no push");
	a_stop_short: assert property (
		stop_exit && operating_mode_control[OMC_SD] |=> stop_wait [*8])
		else $error("stop wait short");
	a_bus_off: assert property (
		$rose(operating_mode_control[OMC_EBD]) |-> ##[0:1]
		!external_bus_enable) else $error("bus still on");
	a_no_grant_off: assert property (
		operating_mode_control[OMC_EBD] && $past(operating_mode_control[OMC_EBD])
		|-> !dma_grant && !core_grant) else $error("grant while off");
	a_core_over_dma: assert property (
		$past(both && sel == CDP_CORE_HIGH) |-> core_grant && !dma_grant)
		else $error("core not first");
	a_dma_over_core: assert property (
		$past(both && sel == CDP_DMA_HIGH) |-> dma_grant && !core_grant)
		else $error("dma not first");
	a_mode_mirror: assert property (
		memory_switch_mode == operating_mode_control[OMC_MS]
		&& rounding_mode == processor_status_word[PSW_RM])
		else $error("mode output differs");
	c_stop: cover property (stop_wait ##1 !stop_wait);
	c_push: cover property (stack_push);
	c_dma: cover property (dma_grant);
endmodule

/* File: verification/core_mode_status_registers_tb.sv */
// Testbench of the mode and status register bank.
`timescale 1ns/1ps
module core_mode_status_registers_tb
	import core_mode_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [10:0] st = '0;
	logic [23:0] wd = '0;
	logic [1:0] rq = '0;
	logic [23:0] omc, psw, spd;
	logic sp, sw, ebe, dg, cg, ms, rm, sm, ce, sa, dm;
	int checks = 0;
	int fail_count = 0;
	// ----------------------------------------
	// Clock, design and checker
	// ----------------------------------------
	always #5 sys_clk = ~sys_clk;
	core_mode_status_registers #(.STOP_LONG(64)) dut (
		.sys_clk, .rst, .mode_select_pins(4'hA), .omc_write(st[0]),
		.omc_wdata(wd), .psw_write(st[1]), .psw_wdata(wd),
		.ccr_alu_write(st[2]), .ccr_alu_data(wd[7:0]),
		.ccr_move_write(st[3]), .ccr_move_data(wd[7:0]),
		.mr_write(st[4]), .mr_wdata(wd[7:0]), .emr_event(st[5]),
		.emr_event_data(wd[7:0]), .forever_loop_start(st[6]),
		.loop_start(st[7]), .loop_restore(st[8]),
		.loop_restore_flags(wd[1:0]), .subroutine_jump(st[9]),
		.stop_exit(st[10]), .dma_channel_priority(2'h2),
		.dma_request(rq[1]), .core_request(rq[0]),
		.operating_mode_control(omc), .processor_status_word(psw),
		.stack_push(sp), .stack_push_data(spd), .stop_wait(sw),
		.external_bus_enable(ebe), .dma_grant(dg), .core_grant(cg),
		.memory_switch_mode(ms), .rounding_mode(rm),
		.saturation_mode(sm), .cache_enable(ce),
		.sixteen_bit_arith(sa), .double_precision_mode(dm)
	);
	// Pulse one strobe with its data for one cycle
	task p(input int i, input logic [23:0] d);
		@(negedge sys_clk);
		st[i] = 1'b1;
		wd = d;
		@(negedge sys_clk);
		st = '0;
	endtask
	// Compare and count
	task chk(input string n, input logic [23:0] s, input logic [23:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task stop_test;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("omc", omc, 24'h00030A);
		chk("psw", psw, PSW_RESET);
		chk("ebe", 24'(ebe), 24'h1);
		for (int i = 0; i < 4; i++) begin
			p(0, 24'(i) << 8);
			chk("omc", omc, 24'(i) << 8);
			rq = 2'h3;
			repeat (2) @(negedge sys_clk);
			if (i != 2) chk("gnt", 24'({dg, cg}), (i == 1) ? 2 : 1);
			rq = 2'h0;
		end
		p(0, 24'hFFFFFF);
		rq = 2'h3;
		repeat (2) @(negedge sys_clk);
		chk("omc", omc, 24'h0003DF);
		chk("bus", 24'({ebe, dg, cg, ms}), 24'h1);
		rq = 2'h0;
		p(1, 24'hFFFFFF);
		chk("psw", psw, 24'hFBEFFF);
		chk("mode", 24'({rm, sm, ce, sa, dm}), 24'h1F);
		p(3, 24'h0);
		chk("psw", psw, 24'hFBEF3F);
		p(2, 24'h5A);
		p(5, 24'h0);
		chk("psw", psw, 24'h00EF5A);
		p(4, 24'h0);
		p(7, 24'h0);
		chk("push", {sp, spd[22:0]}, 24'h80005A);
		chk("psw", psw, 24'h00805A);
		p(6, 24'h0);
		chk("psw", psw, 24'h01805A);
		p(8, 24'h1);
		p(9, 24'h0);
		chk("push", {sp, spd[22:0]}, 24'h80805A);
		for (int i = 0; i < 2; i++) begin
			p(0, i ? 24'h80 : 24'hC0);
			p(10, 24'h0);
			repeat (i ? 40 : 20) @(negedge sys_clk);
			chk("stop", 24'(sw), 24'(i));
		end
		repeat (40) @(negedge sys_clk);
		chk("stop", 24'(sw), 24'h0);
		stop_test();
	end
	// Watchdog against a hang
	initial begin
		#20000;
		fail_count++;
		stop_test();
	end
endmodule
bind core_mode_status_registers core_mode_props chk (
	.sys_clk, .rst, .psw_write, .psw_wdata, .forever_loop_start,
	.loop_start, .subroutine_jump, .stop_exit, .dma_request,
	.core_request, .operating_mode_control, .processor_status_word,
	.stack_push, .stack_push_data, .stop_wait, .external_bus_enable,
	.dma_grant, .core_grant, .memory_switch_mode, .rounding_mode
);
